// file: logic/bus_fault_status_and_rerun.sv
// Purpose: Build the saved bus fault status word and drive rerun on return
// Assumes: Fault events and frame words come from processor logic on CLOCK_IN
// Notes: Bus fault input is a pin and passes a three-stage synchroniser
//
// Notes on behaviour
// - Status word saved at frame offset A
// - Upper half stage bits, lower half data
// - Address error: no fault bits, rerun bits
// - Stage fault set when invalid stage used
// - Rerun set on prefetch fault, implied by fault
// - Rerun plus fault forces prefetch on return
// - Prefetch uses program space of stacked privilege
// - Clear rerun: stage image valid, nothing pending
// - Data fault bit set; rerun data if set
// - Locked flag one for read-modify-write
// - Direction bit one read, zero write
// - Record operand size and function space code
// - Any mix of fault bits reported together
// - Data read fault uses long frame only
// - Short operands right justified in buffers; the output buffer image loaded from the frame is stored unjustified
// - Locked set, data clear: instruction complete
// - Vector offset separates address and bus errors
// - Data fault still set: rerun locked instruction
// - Bus fault while loading frame halts device
`timescale 1ns/1ps
module bus_fault_status_and_rerun
  import fault_status_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic BUS_FAULT_INPUT_IN,
  input wire logic CAPTURE_IN,
  input wire fault_kind_type FAULT_KIND_IN,
  input wire logic DATA_FAULT_IN,
  input wire data_cycle_type DATA_CYCLE_IN,
  input wire pipe_state_type PIPE_STATE_IN,
  input wire logic ADDR_ERR_BOTH_IN,
  input wire logic [31:0] DATA_IN_VALUE_IN,
  input wire logic [31:0] DATA_OUT_VALUE_IN,
  input wire logic RESTORE_START_IN,
  input wire logic FRAME_WR_IN,
  input wire logic [7:0] FRAME_OFFSET_IN,
  input wire logic [15:0] FRAME_WORD_IN,
  input wire logic [31:0] FRAME_LONG_IN,
  input wire logic [15:0] STACKED_STATUS_IN,
  input wire logic FRAME_LOADED_IN,
  input wire logic RERUN_DONE_IN,
  output logic [15:0] FAULT_STATUS_WORD_OUT,
  output logic [7:0] FSW_OFFSET_OUT,
  output logic [3:0] FRAME_FORMAT_OUT,
  output logic [11:0] VECTOR_OFFSET_OUT,
  output logic [31:0] DATA_IN_IMAGE_OUT,
  output logic [31:0] DATA_OUT_IMAGE_OUT,
  output rerun_req_type RERUN_REQ_OUT,
  output logic RERUN_VALID_OUT,
  output logic RESTORE_BUSY_OUT,
  output logic HALTED_OUT
);

  // Size-code aware right justification of a short operand
  function automatic logic [31:0] justify(input logic [31:0] v, input logic [1:0] sz);
    logic [31:0] r;
    r = v;
    case (sz)
      SIZE_BYTE: r = {24'h00_0000, v[7:0]};
      SIZE_WORD: r = {16'h0000, v[15:0]};
      SIZE_THREE: r = {8'h00, v[23:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  // Decode of the privilege bit in a stacked status register copy
  function automatic logic [2:0] prog_space(input logic [15:0] sr);
    return sr[13] ? SPACE_SUPER_PROGRAM : SPACE_USER_PROGRAM;
  endfunction

  // Synchroniser for the bus fault pin
  logic bus_fault_input_s1_r; // First stage, read only by second
  logic bus_fault_input_s2_r; // Second stage
  logic bus_fault_input_s3_r; // Third stage
  logic bus_fault_input_level_r; // Accepted level
  logic bus_fault_input_rise; // Newly accepted assertion

  logic [15:0] fsw_r; // Captured or restored status word
  logic [15:0] fsw_nxt; // Next captured word
  logic [3:0] fmt_r; // Frame format
  logic [11:0] vec_r; // Vector offset
  restore_state_type rs_r; // Restore sequencer state
  restore_state_type rs_nxt; // Next sequencer state
  rerun_req_type req_r; // Registered rerun request
  rerun_req_type req_nxt; // Next rerun request
  logic [15:0] sr_copy_r; // Stacked status register copy
  logic [NUM_STAGES-1:0] stage_fault; // Stage fault bits for capture
  logic [NUM_STAGES-1:0] stage_rerun; // Stage rerun bits for capture
  logic mem_wr; // Image write strobe
  logic [IMG_ADDR_W-1:0] mem_waddr; // Image write index
  logic [31:0] mem_wdata; // Image write data
  logic [IMG_ADDR_W-1:0] mem_raddr; // Image read index
  logic [31:0] mem_rdata; // Image read data
  logic [IMG_ADDR_W-1:0] rd_idx_r; // Index of word on read port
  logic frame_at_fsw; // Frame write hits the status word

  // Three-flop pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      bus_fault_input_s1_r <= 1'b0;
      bus_fault_input_s2_r <= 1'b0;
      bus_fault_input_s3_r <= 1'b0;
      bus_fault_input_level_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      bus_fault_input_s1_r <= BUS_FAULT_INPUT_IN;
      bus_fault_input_s2_r <= bus_fault_input_s1_r;
      bus_fault_input_s3_r <= bus_fault_input_s2_r;
      if (bus_fault_input_s2_r == bus_fault_input_s3_r) begin
        bus_fault_input_level_r <= bus_fault_input_s3_r;
      end
    end
  end

  assign bus_fault_input_rise = (bus_fault_input_s2_r == bus_fault_input_s3_r) && bus_fault_input_s3_r && !bus_fault_input_level_r;

  // Stage bits per stage: index 0 stage B, index 1 stage C
  for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
    // Fault bit only for a bus error when a stage invalidated by its prefetch fault was used
    assign stage_fault[g] = (FAULT_KIND_IN == FK_BUS) && PIPE_STATE_IN.used_invalid[g]
                            && PIPE_STATE_IN.prefetch_faulted[g];
    // Rerun on any faulted prefetch and always when the fault bit is set
    assign stage_rerun[g] = PIPE_STATE_IN.prefetch_faulted[g] || stage_fault[g];
  end

  // Compose the status word from the capture inputs
  always_comb begin
    fsw_nxt = FSW_RESET_VALUE;
    if (FAULT_KIND_IN == FK_ADDRESS) begin
      // Address error: fault bits stay clear, stage C rerun always, B by ADDR_ERR_BOTH_IN
      fsw_nxt[FSW_STAGE_C_RERUN_BIT] = 1'b1;
      fsw_nxt[FSW_STAGE_B_RERUN_BIT] = ADDR_ERR_BOTH_IN;
    end else begin
      // Upper half holds stage bits for C and B
      fsw_nxt[FSW_STAGE_C_FAULT_BIT] = stage_fault[1];
      fsw_nxt[FSW_STAGE_B_FAULT_BIT] = stage_fault[0];
      fsw_nxt[FSW_STAGE_C_RERUN_BIT] = stage_rerun[1];
      fsw_nxt[FSW_STAGE_B_RERUN_BIT] = stage_rerun[0];
    end
    if (DATA_FAULT_IN && FAULT_KIND_IN == FK_BUS) begin
      // Lower half describes the data cycle only
      fsw_nxt[FSW_DATA_FAULT_BIT] = 1'b1;
      fsw_nxt[FSW_LOCKED_BIT] = DATA_CYCLE_IN.locked;
      fsw_nxt[FSW_READ_BIT] = DATA_CYCLE_IN.read;
      fsw_nxt[FSW_SIZE_LSB +: 2] = DATA_CYCLE_IN.size;
      fsw_nxt[FSW_SPACE_LSB +: 3] = DATA_CYCLE_IN.space;
    end
  end

  assign frame_at_fsw = FRAME_WR_IN && (FRAME_OFFSET_IN == FSW_FRAME_OFFSET);

  // Status word: captured on a fault, reloaded from the frame on restore
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      fsw_r <= FSW_RESET_VALUE;
    end else if (CLK_EN_IN) begin
      if (CAPTURE_IN && FAULT_KIND_IN != FK_NONE) begin
        fsw_r <= fsw_nxt;
      end else if (rs_r == RS_LOAD && frame_at_fsw) begin
        // Only data fault and rerun bits can differ from the saved copy
        fsw_r <= (FRAME_WORD_IN & FSW_SW_WRITABLE_MASK)
               | (fsw_r & ~FSW_SW_WRITABLE_MASK);
      end
    end
  end

  // Frame format and vector offset chosen at capture
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      fmt_r <= FRAME_FMT_SHORT;
      vec_r <= VEC_OFFSET_BUS_ERROR;
    end else if (CLK_EN_IN && CAPTURE_IN && FAULT_KIND_IN != FK_NONE) begin
      // Distinct vector offsets tell the two fault kinds apart
      vec_r <= (FAULT_KIND_IN == FK_ADDRESS) ? VEC_OFFSET_ADDR_ERROR
                                             : VEC_OFFSET_BUS_ERROR;
      // A data read fault forces the long frame
      fmt_r <= (DATA_FAULT_IN && DATA_CYCLE_IN.read) ? FRAME_FMT_LONG
                                                     : FRAME_FMT_SHORT;
    end
  end

  // Stacked status register copy taken when the restore starts from idle
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      sr_copy_r <= 16'h0000;
    end else if (CLK_EN_IN && RESTORE_START_IN && rs_r == RS_IDLE) begin
      sr_copy_r <= STACKED_STATUS_IN;
    end
  end

  // Image memory writes: buffers at capture, handler images at load
  always_comb begin
    mem_wr = 1'b0;
    mem_waddr = IMG_IDX_FSW;
    mem_wdata = 32'h0000_0000;
    if (CAPTURE_IN && DATA_FAULT_IN) begin
      mem_wr = 1'b1;
      mem_waddr = DATA_CYCLE_IN.read ? IMG_IDX_DIN : IMG_IDX_DOUT;
      mem_wdata = justify(DATA_CYCLE_IN.read ? DATA_IN_VALUE_IN : DATA_OUT_VALUE_IN,
                          DATA_CYCLE_IN.size);
    end else if (rs_r == RS_LOAD && FRAME_WR_IN
                 && FRAME_OFFSET_IN == FRAME_DATA_IN_OFFSET) begin
      // Handler-filled input buffer of the long frame
      mem_wr = 1'b1;
      mem_waddr = IMG_IDX_DIN;
      mem_wdata = justify(FRAME_LONG_IN, fsw_r[FSW_SIZE_LSB +: 2]);
    end else if (rs_r == RS_LOAD && FRAME_WR_IN
                 && FRAME_OFFSET_IN == FRAME_DATA_OUT_OFFSET) begin
      mem_wr = 1'b1;
      mem_waddr = IMG_IDX_DOUT;
      mem_wdata = FRAME_LONG_IN;
    end
  end

  // Read port alternates over the two buffers so both outputs refresh
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      rd_idx_r <= IMG_IDX_DIN;
    end else if (CLK_EN_IN) begin
      rd_idx_r <= mem_raddr;
    end
  end

  assign mem_raddr = (rd_idx_r == IMG_IDX_DIN) ? IMG_IDX_DOUT : IMG_IDX_DIN;

  // Buffer memory
  fault_image_mem u_img (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .en_in(CLK_EN_IN),
    .wr_in(mem_wr),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // Capture read data into the matching output register
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      DATA_IN_IMAGE_OUT <= 32'h0000_0000;
      DATA_OUT_IMAGE_OUT <= 32'h0000_0000;
    end else if (CLK_EN_IN) begin
      if (rd_idx_r == IMG_IDX_DIN) begin
        DATA_IN_IMAGE_OUT <= mem_rdata;
      end else begin
        DATA_OUT_IMAGE_OUT <= mem_rdata;
      end
    end
  end

  // Rerun decisions from the restored word
  always_comb begin
    req_nxt = '0;
    req_nxt.prefetch_space = prog_space(sr_copy_r);
    // Rerun plus fault: prefetch must run; rerun alone: may run; clear: none
    req_nxt.prefetch_must[1] = fsw_r[FSW_STAGE_C_RERUN_BIT] && fsw_r[FSW_STAGE_C_FAULT_BIT];
    req_nxt.prefetch_must[0] = fsw_r[FSW_STAGE_B_RERUN_BIT] && fsw_r[FSW_STAGE_B_FAULT_BIT];
    req_nxt.prefetch_may[1] = fsw_r[FSW_STAGE_C_RERUN_BIT];
    req_nxt.prefetch_may[0] = fsw_r[FSW_STAGE_B_RERUN_BIT];
    if (fsw_r[FSW_LOCKED_BIT]) begin
      // Locked cycle: whole instruction reruns or counts as done
      req_nxt.whole_locked = fsw_r[FSW_DATA_FAULT_BIT];
      req_nxt.locked_done = !fsw_r[FSW_DATA_FAULT_BIT];
    end else begin
      req_nxt.data_rerun = fsw_r[FSW_DATA_FAULT_BIT];
    end
  end

  // Restore sequencer
  always_comb begin
    rs_nxt = rs_r;
    case (rs_r)
      RS_IDLE: begin
        if (RESTORE_START_IN) begin
          rs_nxt = RS_LOAD;
        end
      end
      RS_LOAD: begin
        if (bus_fault_input_rise || bus_fault_input_level_r) begin
          rs_nxt = RS_HALTED;
        end else if (FRAME_LOADED_IN) begin
          rs_nxt = RS_RERUN_DATA;
        end
      end
      RS_RERUN_DATA: begin
        rs_nxt = RS_RERUN_PREFETCH;
      end
      RS_RERUN_PREFETCH: begin
        if (RERUN_DONE_IN) begin
          rs_nxt = RS_DONE;
        end
      end
      RS_DONE: begin
        rs_nxt = RS_IDLE;
      end
      RS_HALTED: begin
        rs_nxt = RS_HALTED; // Left only by reset
      end
      default: begin
        rs_nxt = RS_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      rs_r <= RS_IDLE;
    end else if (CLK_EN_IN) begin
      rs_r <= rs_nxt;
    end
  end

  // Rerun request register, latched once the frame is fully loaded
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      req_r <= '0;
    end else if (CLK_EN_IN && rs_r == RS_RERUN_DATA) begin
      req_r <= req_nxt;
    end
  end

  // Outputs
  assign FAULT_STATUS_WORD_OUT = fsw_r;
  assign FSW_OFFSET_OUT = FSW_FRAME_OFFSET;
  assign FRAME_FORMAT_OUT = fmt_r;
  assign VECTOR_OFFSET_OUT = vec_r;
  assign RERUN_REQ_OUT = req_r;
  assign RERUN_VALID_OUT = (rs_r == RS_RERUN_PREFETCH);
  assign RESTORE_BUSY_OUT = (rs_r != RS_IDLE) && (rs_r != RS_HALTED);
  assign HALTED_OUT = (rs_r == RS_HALTED);

endmodule // bus_fault_status_and_rerun

// file: logic/fault_image_mem.sv
// Purpose: Small register memory holding restored frame words
// Assumes: Single clock, one write and one registered read port
// Notes: Read data always come out of a register
`timescale 1ns/1ps
module fault_image_mem
  import fault_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic wr_in,
  input wire logic [IMG_ADDR_W-1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [IMG_ADDR_W-1:0] raddr_in,
  output logic [31:0] rdata_out
);

  logic [31:0] mem_r [IMG_DEPTH]; // Storage words

  // Write port, cleared on reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < IMG_DEPTH; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else if (en_in && wr_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (en_in) begin
      rdata_out <= mem_r[raddr_in];
    end
  end

endmodule // fault_image_mem

// file: logic/fault_status_pkg.sv
// Purpose: Shared constants and types for the bus fault status capture and rerun unit
// Assumes: One clock, synchronous active-high reset
// Notes: Field layout of the saved status word is fixed here; reserved bits read zero
package fault_status_pkg;

  // Frame offset of the saved status word (bytes from frame base)
  localparam logic [7:0] FSW_FRAME_OFFSET = 8'h0A;
  // Frame offsets of related frame items
  localparam logic [7:0] FRAME_DATA_OUT_OFFSET = 8'h18;
  localparam logic [7:0] FRAME_FAULT_ADDR_OFFSET = 8'h10;
  localparam logic [7:0] FRAME_DATA_IN_OFFSET = 8'h2C;

  // Status word bit positions
  localparam int FSW_STAGE_C_FAULT_BIT = 15;
  localparam int FSW_STAGE_B_FAULT_BIT = 14;
  localparam int FSW_STAGE_C_RERUN_BIT = 13;
  localparam int FSW_STAGE_B_RERUN_BIT = 12;
  localparam int FSW_DATA_FAULT_BIT = 8;
  localparam int FSW_LOCKED_BIT = 7;
  localparam int FSW_READ_BIT = 6;
  localparam int FSW_SIZE_LSB = 4;
  localparam int FSW_SPACE_LSB = 0;

  // Mask of bits software may change on the stacked word
  localparam logic [15:0] FSW_SW_WRITABLE_MASK = 16'h3100;
  // Reset value of the captured word
  localparam logic [15:0] FSW_RESET_VALUE = 16'h0000;

  // Vector offsets that tell fault kinds apart in the format word
  localparam logic [11:0] VEC_OFFSET_BUS_ERROR = 12'h008;
  localparam logic [11:0] VEC_OFFSET_ADDR_ERROR = 12'h00C;

  // Frame formats
  localparam logic [3:0] FRAME_FMT_SHORT = 4'hA;
  localparam logic [3:0] FRAME_FMT_LONG = 4'hB;

  // Program space codes for instruction rerun
  localparam logic [2:0] SPACE_USER_PROGRAM = 3'h2;
  localparam logic [2:0] SPACE_SUPER_PROGRAM = 3'h6;

  // Operand size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // Number of instruction stages tracked (index 0 is stage B, 1 is stage C)
  localparam int NUM_STAGES = 2;
  // Depth of the restore image memory (status word plus data buffers)
  localparam int IMG_DEPTH = 4;
  localparam int IMG_ADDR_W = 2;
  localparam logic [1:0] IMG_IDX_FSW = 2'h0;
  localparam logic [1:0] IMG_IDX_DIN = 2'h1;
  localparam logic [1:0] IMG_IDX_DOUT = 2'h2;

  // Restore sequencer states
  typedef enum logic [2:0] {
    RS_IDLE,
    RS_LOAD,
    RS_RERUN_DATA,
    RS_RERUN_PREFETCH,
    RS_DONE,
    RS_HALTED
  } restore_state_type;

  // Fault kind at capture time
  typedef enum logic [1:0] {
    FK_NONE,
    FK_ADDRESS,
    FK_BUS
  } fault_kind_type;

  // Description of the faulted data cycle
  typedef struct packed {
    logic       locked;  // Part of a read-modify-write
    logic       read;    // 1 read, 0 write
    logic [1:0] size;    // Operand size code
    logic [2:0] space;   // Function space code
  } data_cycle_type;

  // Pipeline stage condition at capture time
  typedef struct packed {
    logic [NUM_STAGES-1:0] prefetch_faulted; // Prefetch saw a bus error
    logic [NUM_STAGES-1:0] used_invalid;     // Stage used while invalid
  } pipe_state_type;

  // Rerun requests issued at return from exception
  typedef struct packed {
    logic       data_rerun;     // Rerun faulted data access
    logic       whole_locked;   // Rerun whole locked instruction
    logic       locked_done;    // Locked instruction taken as complete
    logic [1:0] prefetch_must;  // Prefetch rerun that must run
    logic [1:0] prefetch_may;   // Prefetch that may run if needed
    logic [2:0] prefetch_space; // Program space for prefetch
  } rerun_req_type;

endpackage : fault_status_pkg

// file: sim/fault_status_asserts.sv
// Purpose: Concurrent checks on the fault status capture and rerun ports
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps
module fault_status_asserts
  import fault_status_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic CAPTURE_IN,
  input wire fault_kind_type FAULT_KIND_IN,
  input wire logic DATA_FAULT_IN,
  input wire data_cycle_type DATA_CYCLE_IN,
  input wire pipe_state_type PIPE_STATE_IN,
  input wire logic ADDR_ERR_BOTH_IN,
  input wire logic [15:0] FAULT_STATUS_WORD_OUT,
  input wire logic [7:0] FSW_OFFSET_OUT,
  input wire logic [3:0] FRAME_FORMAT_OUT,
  input wire logic [11:0] VECTOR_OFFSET_OUT,
  input wire rerun_req_type RERUN_REQ_OUT,
  input wire logic RERUN_VALID_OUT,
  input wire logic HALTED_OUT
);
  // Capture strobes by fault kind
  wire logic cap_any = CLK_EN_IN && CAPTURE_IN && (FAULT_KIND_IN != FK_NONE);
  wire logic cap_bus = cap_any && (FAULT_KIND_IN == FK_BUS);
  wire logic cap_adr = cap_any && (FAULT_KIND_IN == FK_ADDRESS);
  wire logic [15:0] w = FAULT_STATUS_WORD_OUT;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_fsw_offset_const: assert property (FSW_OFFSET_OUT == 8'h0A)
    else $error("status word offset wrong");
  a_addr_rerun_only: assert property (cap_adr |=> w[15:14] == 2'h0 && w[13]
    && w[12] == $past(ADDR_ERR_BOTH_IN)) else $error("address error stage bits wrong");
  a_stage_fault_bits: assert property (cap_bus |=>
    w[15:14] == $past(PIPE_STATE_IN.used_invalid & PIPE_STATE_IN.prefetch_faulted)
    && w[13:12] == ($past(PIPE_STATE_IN.prefetch_faulted) | w[15:14]))
    else $error("bus error stage bits wrong");
  a_data_cycle_fields: assert property (cap_bus && DATA_FAULT_IN |=>
    w[8:0] == {1'b1, $past(DATA_CYCLE_IN[6:3]), 1'b0, $past(DATA_CYCLE_IN.space)})
    else $error("data cycle fields wrong");
  a_reserved_bits_zero: assert property (w[11:9] == 3'h0 && !w[3])
    else $error("reserved status bits set");
  a_vector_by_kind: assert property (cap_any |=> VECTOR_OFFSET_OUT ==
    (($past(FAULT_KIND_IN) == FK_ADDRESS) ? 12'h00C : 12'h008)) else $error("vector wrong");
  a_read_long_frame: assert property (cap_bus && DATA_FAULT_IN && DATA_CYCLE_IN.read
    |=> FRAME_FORMAT_OUT == 4'hB) else $error("read fault not long frame");
  a_req_prefetch: assert property (RERUN_VALID_OUT |->
    RERUN_REQ_OUT.prefetch_must == (w[15:14] & w[13:12])
    && RERUN_REQ_OUT.prefetch_may == w[13:12]) else $error("prefetch request wrong");
  a_req_data_lock: assert property (RERUN_VALID_OUT |->
    RERUN_REQ_OUT.data_rerun == (w[8] & !w[7]) && RERUN_REQ_OUT.whole_locked == (w[8] & w[7])
    && RERUN_REQ_OUT.locked_done == (!w[8] & w[7])) else $error("data rerun request wrong");
  a_halt_holds: assert property (HALTED_OUT |=> HALTED_OUT)
    else $error("halted state left without reset");
endmodule // fault_status_asserts

bind bus_fault_status_and_rerun fault_status_asserts u_chk (
  .CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(CLK_EN_IN),
  .CAPTURE_IN(CAPTURE_IN), .FAULT_KIND_IN(FAULT_KIND_IN), .DATA_FAULT_IN(DATA_FAULT_IN),
  .DATA_CYCLE_IN(DATA_CYCLE_IN), .PIPE_STATE_IN(PIPE_STATE_IN),
  .ADDR_ERR_BOTH_IN(ADDR_ERR_BOTH_IN), .FAULT_STATUS_WORD_OUT(FAULT_STATUS_WORD_OUT),
  .FSW_OFFSET_OUT(FSW_OFFSET_OUT), .FRAME_FORMAT_OUT(FRAME_FORMAT_OUT),
  .VECTOR_OFFSET_OUT(VECTOR_OFFSET_OUT), .RERUN_REQ_OUT(RERUN_REQ_OUT),
  .RERUN_VALID_OUT(RERUN_VALID_OUT), .HALTED_OUT(HALTED_OUT));

// file: sim/tb_top.sv
// Purpose: Directed bench for fault status capture, frame restore and rerun requests
// Assumes: Inputs change on the falling edge, 250 MHz clock
// Notes: Clock enable is held high; long frame data change only in the restore task
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
  import fault_status_pkg::*;
  logic clk = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic bus_fault = 1'b0; // Asynchronous bus fault pin
  logic capture = 1'b0; // Capture strobe
  fault_kind_type kind = FK_NONE; // Fault kind at capture
  logic dfault = 1'b0; // Data cycle faulted
  data_cycle_type dcyc = '0; // Faulted data cycle
  pipe_state_type pipe = '0; // Pipeline condition
  logic aboth = 1'b0; // Address error reruns both stages
  logic [31:0] din_v = '0; // Data input buffer value
  logic [31:0] dout_v = '0; // Data output buffer value
  logic start = 1'b0; // Restore start
  logic fwr = 1'b0; // Frame word write
  logic [7:0] foff = '0; // Frame offset
  logic [15:0] fword = '0; // Frame word
  logic [31:0] flong = 32'h0000_0000; // Frame long word
  logic [15:0] sr = '0; // Stacked status word copy
  logic loaded = 1'b0; // Frame load finished
  logic rdone = 1'b0; // Reruns finished
  logic [15:0] word; // Saved status word
  logic [7:0] offs; // Status word offset
  logic [3:0] fmt; // Frame format
  logic [11:0] vec; // Vector offset
  logic [31:0] din_img; // Data input image
  logic [31:0] dout_img; // Data output image
  rerun_req_type req; // Rerun requests
  logic rvalid; // Rerun requests valid
  logic busy; // Restore in progress
  logic halted; // Halted state
  int bad_count = 0; // Mismatches seen
  int num_checks = 0; // Comparisons made
  logic [15:0] ew; // Expected status word

  // Clock generator, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end

  bus_fault_status_and_rerun dut (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .BUS_FAULT_INPUT_IN(bus_fault),
    .CAPTURE_IN(capture), .FAULT_KIND_IN(kind), .DATA_FAULT_IN(dfault), .DATA_CYCLE_IN(dcyc),
    .PIPE_STATE_IN(pipe), .ADDR_ERR_BOTH_IN(aboth), .DATA_IN_VALUE_IN(din_v),
    .DATA_OUT_VALUE_IN(dout_v), .RESTORE_START_IN(start), .FRAME_WR_IN(fwr),
    .FRAME_OFFSET_IN(foff), .FRAME_WORD_IN(fword), .FRAME_LONG_IN(flong),
    .STACKED_STATUS_IN(sr), .FRAME_LOADED_IN(loaded), .RERUN_DONE_IN(rdone),
    .FAULT_STATUS_WORD_OUT(word), .FSW_OFFSET_OUT(offs), .FRAME_FORMAT_OUT(fmt),
    .VECTOR_OFFSET_OUT(vec), .DATA_IN_IMAGE_OUT(din_img), .DATA_OUT_IMAGE_OUT(dout_img),
    .RERUN_REQ_OUT(req), .RERUN_VALID_OUT(rvalid), .RESTORE_BUSY_OUT(busy),
    .HALTED_OUT(halted));

  // Prints the counts and the verdict, then stops
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and counts it
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH at %0t got %0h expected %0h", $time, g, e);
      bad_count++;
    end
  endtask

  // Level selector for bounded waits
  function automatic logic sel_sig(input int s);
    case (s)
      0: return busy;
      1: return rvalid;
      2: return halted;
      default: return ~busy;
    endcase
  endfunction

  // Waits a bounded time for a level, ends the run on timeout
  task automatic wait_on(input int s);
    int i;
    for (i = 0; i < 40 && sel_sig(s) !== 1'b1; i++) @(negedge clk);
    if (sel_sig(s) !== 1'b1) begin
      $display("MISMATCH at %0t got %0h expected %0h", $time, 1'b0, 1'b1);
      bad_count++;
      final_report();
    end
  endtask

  // Expected word from the capture inputs
  function automatic logic [15:0] exp_word();
    logic [1:0] f;
    f = pipe.used_invalid & pipe.prefetch_faulted;
    if (kind == FK_ADDRESS) return {2'b00, 1'b1, aboth, 12'h000};
    return {f, pipe.prefetch_faulted | f, 3'h0, dfault, dcyc[6:3], 1'b0, dcyc.space};
  endfunction

  // Expected rerun requests from the loaded word and privilege
  function automatic rerun_req_type req_of(input logic [15:0] w, input logic [15:0] s);
    rerun_req_type r;
    r.prefetch_must = w[15:14] & w[13:12];
    r.prefetch_may = w[13:12];
    r.whole_locked = w[8] & w[7];
    r.locked_done = ~w[8] & w[7];
    r.data_rerun = w[8] & ~w[7];
    r.prefetch_space = s[13] ? SPACE_SUPER_PROGRAM : SPACE_USER_PROGRAM;
    return r;
  endfunction

  // Right-justified mask for a size code
  function automatic logic [31:0] size_mask(input logic [1:0] s);
    return (s == SIZE_BYTE) ? 32'h0000_00FF : (s == SIZE_WORD) ? 32'h0000_FFFF :
      (s == SIZE_THREE) ? 32'h00FF_FFFF : 32'hFFFF_FFFF;
  endfunction

  // One capture pulse, then let the buffer images settle
  task automatic cap_fault();
    capture = 1'b1;
    @(negedge clk);
    capture = 1'b0;
    ew = exp_word();
    repeat (4) @(negedge clk);
  endtask

  // Restore sequence: start, status word write, unmapped write, load, rerun
  task automatic restore(input logic [15:0] s, input logic [15:0] w);
    sr = s;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_on(0);
    fwr = 1'b1;
    foff = FSW_FRAME_OFFSET;
    fword = w;
    @(negedge clk);
    foff = 8'h40;
    fword = 16'hFFFF;
    @(negedge clk);
    foff = FRAME_DATA_IN_OFFSET;
    flong = 32'h89AB_CDEF;
    @(negedge clk);
    fwr = 1'b0;
    loaded = 1'b1;
    @(negedge clk);
    loaded = 1'b0;
    ew = (ew & ~FSW_SW_WRITABLE_MASK) | (w & FSW_SW_WRITABLE_MASK);
    wait_on(1);
    `CHK(word, ew);
    `CHK(req, req_of(ew, s));
    rdone = 1'b1;
    @(negedge clk);
    rdone = 1'b0;
    wait_on(3);
    `CHK(din_img, flong & size_mask(ew[5:4]));
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK({word, offs, fmt}, {FSW_RESET_VALUE, 8'h0A, FRAME_FMT_SHORT});
    `CHK({vec, busy, halted}, {VEC_OFFSET_BUS_ERROR, 2'b00});
    $display("test reset done");
    kind = FK_ADDRESS;
    for (int b = 0; b < 2; b++) begin
      aboth = b[0];
      pipe = '0;
      cap_fault();
      `CHK(word[15:8], ew[15:8]);
      `CHK(vec, VEC_OFFSET_ADDR_ERROR);
    end
    $display("test address error done");
    kind = FK_BUS;
    dfault = 1'b1;
    pipe = '{prefetch_faulted: 2'b10, used_invalid: 2'b01};
    for (int s = 0; s < 4; s++) begin
      dcyc = '{locked: 1'b0, read: 1'b0, size: s[1:0], space: 3'h5};
      din_v = 32'h1234_5678;
      dout_v = 32'h9ABC_DEF0;
      cap_fault();
      `CHK(word, ew);
      `CHK({fmt, vec}, {FRAME_FMT_SHORT, VEC_OFFSET_BUS_ERROR});
      `CHK(din_img, 32'h0000_0000);
      `CHK(dout_img, dout_v & size_mask(s[1:0]));
    end
    $display("test write faults done");
    dcyc = '{locked: 1'b1, read: 1'b1, size: SIZE_LONG, space: 3'h1};
    pipe = '{prefetch_faulted: 2'b10, used_invalid: 2'b10};
    cap_fault();
    `CHK(word, ew);
    `CHK(fmt, FRAME_FMT_LONG);
    `CHK(din_img, din_v);
    restore(16'h2000, 16'hFFFF);
    restore(16'h0000, 16'h0000);
    $display("test locked restore done");
    dcyc = '{locked: 1'b0, read: 1'b1, size: SIZE_WORD, space: 3'h2};
    pipe = '0;
    cap_fault();
    restore(16'h0000, 16'h0100);
    $display("test data rerun done");
    sr = 16'h0000;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_on(0);
    bus_fault = 1'b1;
    wait_on(2);
    `CHK(halted, 1'b1);
    bus_fault = 1'b0;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK({halted, busy, word}, {2'b00, FSW_RESET_VALUE});
    $display("test halt done");
    final_report();
  end
endmodule // tb_top
